// *** design/acq_defs.vh ***
`ifndef ACQ_DEFS_VH
`define ACQ_DEFS_VH

// Register word indices and byte addresses.
`define ACQ_CFG_IDX 8'h62
`define ACQ_CFG_ADDR 12'h188
`define ACQ_IRQ_STAT_ADDR 12'h200
`define ACQ_IRQ_CLR_ADDR 12'h204
`define ACQ_IRQ_EN_ADDR 12'h208
`define ACQ_ACC_UPPER_ADDR 12'h20c
`define ACQ_ACC_LOWER_ADDR 12'h210
`define ACQ_CAL_OFFSET_ADDR 12'h214

// Configuration register field positions.
`define ACQ_STUCK_BIT 15
`define ACQ_CAL_BIT 14
`define ACQ_ACC_BIT 13
`define ACQ_OVERSAMPLE_FREQ_SEL_HI 12
`define ACQ_OVERSAMPLE_FREQ_SEL_LO 11
`define ACQ_THERM_BIAS_PIN_HI 10
`define ACQ_THERM_BIAS_PIN_LO 9
`define ACQ_CFG_USED_LO 9

// Reset values.
`define ACQ_CFG_RST 7'h00
`define ACQ_IRQ_RST 5'h00
`define ACQ_THR_RST 12'h000
`define ACQ_CAL_RST 12'h000

// Interrupt status bit positions.
`define ACQ_IRQ_ZS 0
`define ACQ_IRQ_FS 1
`define ACQ_IRQ_OVER 2
`define ACQ_IRQ_UNDER 3
`define ACQ_IRQ_DONE 4

// Scan configuration codes and expected stuck-at results.
`define ACQ_SCAN_CMP_ONLY 3'h2
`define ACQ_SCAN_BOTH 3'h1
`define ACQ_ZS_EXPECT 12'h000
`define ACQ_FS_EXPECT 12'hfff
`define ACQ_RES_MAX 12'hfff

// Clock rate and oversampling frequencies in Hz.
`define ACQ_CLK_HZ 200000000
`define ACQ_OVERSAMPLE_FREQ_SEL_50_HZ 1600
`define ACQ_OVERSAMPLE_FREQ_SEL_60_HZ 1920
`define ACQ_DIV_50 (`ACQ_CLK_HZ / `ACQ_OVERSAMPLE_FREQ_SEL_50_HZ)
`define ACQ_DIV_60 (`ACQ_CLK_HZ / `ACQ_OVERSAMPLE_FREQ_SEL_60_HZ)

`endif

// *** design/rate_tick_gen.v ***
`timescale 1ns/100ps
`include "acq_defs.vh"

module rate_tick_gen #(
	parameter integer CNT_W = 17,
	parameter integer DIV_50 = `ACQ_DIV_50,
	parameter integer DIV_60 = `ACQ_DIV_60
) (
	// Clock and reset.
	input wire sys_clk,
	input wire reset_n,
	// Rate selection.
	input wire paced,
	input wire [1:0] freq_sel,
	// Sample enable.
	output reg tick
);

	reg [CNT_W-1:0] cnt_r;
	wire [CNT_W-1:0] div_cnt;
	wire fixed;

	assign fixed = paced && (freq_sel != 2'b00);
	assign div_cnt = freq_sel[1] ? DIV_60[CNT_W-1:0] : DIV_50[CNT_W-1:0];

	////////////////////////////////////////////////////////////////////////
	// Free pace holds the enable high, a fixed rate pulses it once a period.
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			cnt_r <= {CNT_W{1'b0}};
			tick <= 1'b0;
		end else if (!fixed) begin
			cnt_r <= {CNT_W{1'b0}};
			tick <= 1'b1;
		end else if (cnt_r >= div_cnt - {{(CNT_W-1){1'b0}}, 1'b1}) begin
			cnt_r <= {CNT_W{1'b0}};
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
			tick <= 1'b0;
		end
	end

endmodule

// *** design/acquisition_config_control.v ***
// Functional notes
// - Stuck bit set: after each converter sequence force zero- and full-scale inputs.
// - Forced-low result not 000 raises zero alert; forced-high not fff raises full alert.
// - Calibration correction applied to converter results only while calibration bit set.
// - Comparator results pass unchanged whatever the calibration bit says.
// - Accuracy bit set: after comparator sequences test through the quarter-gain path.
// - Accuracy result above upper or below lower threshold raises over or under alert.
// - Frequency field: 00 free, 01 gives 1.60 kHz, 1x gives 1.92 kHz.
// - Selected frequency applies only while the oversampling ratio is above 000.
// - Field 00 runs at the fastest rate the engine's own workload allows.
// - Bias mode: 0x closed during acquisition, 10 always open, 11 always closed.
`timescale 1ns/100ps
`include "acq_defs.vh"

module acquisition_config_control #(
	parameter integer DIV_50 = `ACQ_DIV_50,
	parameter integer DIV_60 = `ACQ_DIV_60,
	parameter integer RES_W = 12
) (
	// Clock and reset.
	input wire sys_clk,
	input wire reset_n,
	// AHB-Lite slave.
	input wire hsel,
	input wire [11:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hready,
	input wire [31:0] hwdata,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	// Measurement engine sequence control.
	input wire seq_start,
	input wire [2:0] scan_config,
	input wire [2:0] oversample_ratio_sel,
	input wire seq_done,
	output wire acq_active,
	output wire seq_busy,
	output wire sample_tick,
	// Converter path.
	input wire conv_valid,
	input wire [RES_W-1:0] conv_data,
	output reg conv_force_low,
	output reg conv_force_high,
	output reg diag_conv_req,
	output reg result_valid,
	output reg [RES_W-1:0] result_data,
	// Comparator path.
	input wire cmp_valid,
	input wire [RES_W-1:0] cmp_data,
	output reg quarter_gain_path,
	output reg diag_cmp_req,
	output reg cmp_result_valid,
	output reg [RES_W-1:0] cmp_result_data,
	// Thermistor bias switch.
	output wire therm_bias_pin,
	// Alerts and interrupt.
	output wire alert_conv_zero_scale,
	output wire alert_conv_full_scale,
	output wire alert_cmp_acc_over,
	output wire alert_cmp_acc_under,
	output wire irq
);

	localparam [2:0] ST_IDLE = 3'd0;
	localparam [2:0] ST_ACQ = 3'd1;
	localparam [2:0] ST_ZS_REQ = 3'd2;
	localparam [2:0] ST_ZS_WAIT = 3'd3;
	localparam [2:0] ST_FS_REQ = 3'd4;
	localparam [2:0] ST_FS_WAIT = 3'd5;
	localparam [2:0] ST_CA_REQ = 3'd6;
	localparam [2:0] ST_CA_WAIT = 3'd7;

	// Configuration field storage, bits 15 down to 9.
	reg [6:0] cfg_r;
	reg [4:0] irq_stat_r;
	reg [4:0] irq_stat_nxt;
	reg [4:0] irq_en_r;
	reg [RES_W-1:0] acc_upper_r;
	reg [RES_W-1:0] acc_lower_r;
	reg [RES_W-1:0] cal_offset_r;
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [2:0] scan_r;
	reg wr_pend_r;
	reg rd_pend_r;
	reg [11:0] addr_r;
	reg [4:0] ev_set;
	reg [4:0] ev_clr;
	reg [31:0] rd_mux;
	reg therm_bias_r;

	wire stuck_en;
	wire cal_en;
	wire acc_en;
	wire [1:0] freq_sel;
	wire [1:0] therm_bias_pin_mode;
	wire bus_take;
	wire conv_used;
	wire cmp_used;

	////////////////////////////////////////////////////////////////////////
	// Saturating signed offset addition for calibration correction.
	function [RES_W-1:0] cal_correct;
		input [RES_W-1:0] raw;
		input [RES_W-1:0] offs;
		reg [RES_W+1:0] sum;
		begin
			sum = {2'b00, raw} + {{2{offs[RES_W-1]}}, offs};
			if (sum[RES_W+1])
				cal_correct = {RES_W{1'b0}};
			else if (sum[RES_W])
				cal_correct = `ACQ_RES_MAX;
			else
				cal_correct = sum[RES_W-1:0];
		end
	endfunction

	assign stuck_en = cfg_r[`ACQ_STUCK_BIT - `ACQ_CFG_USED_LO];
	assign cal_en = cfg_r[`ACQ_CAL_BIT - `ACQ_CFG_USED_LO];
	assign acc_en = cfg_r[`ACQ_ACC_BIT - `ACQ_CFG_USED_LO];
	assign freq_sel = cfg_r[`ACQ_OVERSAMPLE_FREQ_SEL_HI - `ACQ_CFG_USED_LO:`ACQ_OVERSAMPLE_FREQ_SEL_LO - `ACQ_CFG_USED_LO];
	assign therm_bias_pin_mode = cfg_r[`ACQ_THERM_BIAS_PIN_HI - `ACQ_CFG_USED_LO:`ACQ_THERM_BIAS_PIN_LO - `ACQ_CFG_USED_LO];

	////////////////////////////////////////////////////////////////////////
	// Bus slave: writes land in the data phase, reads take one wait state.
	// Only whole-word transfers are expected, so hsize is not decoded.
	assign bus_take = hsel && htrans[1] && hready;
	assign hreadyout = !rd_pend_r;
	assign hresp = 1'b0;

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r <= 12'h000;
		end else begin
			wr_pend_r <= bus_take && hwrite;
			rd_pend_r <= bus_take && !hwrite;
			if (bus_take)
				addr_r <= haddr;
		end
	end

	// Unmapped addresses and the clear register read back as zero.
	always @* begin
		rd_mux = 32'h00000000;
		case (addr_r)
			`ACQ_CFG_ADDR: rd_mux = {16'h0000, cfg_r, 9'h000};
			`ACQ_IRQ_STAT_ADDR: rd_mux = {27'h0000000, irq_stat_r};
			`ACQ_IRQ_EN_ADDR: rd_mux = {27'h0000000, irq_en_r};
			`ACQ_ACC_UPPER_ADDR: rd_mux = {20'h00000, acc_upper_r};
			`ACQ_ACC_LOWER_ADDR: rd_mux = {20'h00000, acc_lower_r};
			`ACQ_CAL_OFFSET_ADDR: rd_mux = {20'h00000, cal_offset_r};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always @(posedge sys_clk) begin
		if (!reset_n)
			hrdata <= 32'h00000000;
		else if (rd_pend_r)
			hrdata <= rd_mux;
	end

	////////////////////////////////////////////////////////////////////////
	// Software registers.
	// The status register is read-only; a write to it falls to the default branch.
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			cfg_r <= `ACQ_CFG_RST;
			irq_en_r <= `ACQ_IRQ_RST;
			acc_upper_r <= `ACQ_THR_RST;
			acc_lower_r <= `ACQ_THR_RST;
			cal_offset_r <= `ACQ_CAL_RST;
		end else if (wr_pend_r) begin
			case (addr_r)
				`ACQ_CFG_ADDR: cfg_r <= hwdata[15:`ACQ_CFG_USED_LO];
				`ACQ_IRQ_EN_ADDR: irq_en_r <= hwdata[4:0];
				`ACQ_ACC_UPPER_ADDR: acc_upper_r <= hwdata[RES_W-1:0];
				`ACQ_ACC_LOWER_ADDR: acc_lower_r <= hwdata[RES_W-1:0];
				`ACQ_CAL_OFFSET_ADDR: cal_offset_r <= hwdata[RES_W-1:0];
				default: cfg_r <= cfg_r;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequence controller with end-of-sequence diagnostics.
	// A result strobe in a request cycle is ignored; results count only in wait states.
	assign conv_used = (scan_r != `ACQ_SCAN_CMP_ONLY);
	assign cmp_used = (scan_r == `ACQ_SCAN_BOTH) || (scan_r == `ACQ_SCAN_CMP_ONLY);
	assign acq_active = (state_r == ST_ACQ);
	assign seq_busy = (state_r != ST_IDLE);

	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (seq_start)
					state_nxt = ST_ACQ;
			end
			ST_ACQ: begin
				if (seq_done) begin
					if (stuck_en && conv_used)
						state_nxt = ST_ZS_REQ;
					else if (acc_en && cmp_used)
						state_nxt = ST_CA_REQ;
					else
						state_nxt = ST_IDLE;
				end
			end
			ST_ZS_REQ: state_nxt = ST_ZS_WAIT;
			ST_ZS_WAIT: begin
				if (conv_valid)
					state_nxt = ST_FS_REQ;
			end
			ST_FS_REQ: state_nxt = ST_FS_WAIT;
			ST_FS_WAIT: begin
				if (conv_valid) begin
					if (acc_en && cmp_used)
						state_nxt = ST_CA_REQ;
					else
						state_nxt = ST_IDLE;
				end
			end
			ST_CA_REQ: state_nxt = ST_CA_WAIT;
			ST_CA_WAIT: begin
				if (cmp_valid)
					state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			state_r <= ST_IDLE;
			scan_r <= 3'h0;
			conv_force_low <= 1'b0;
			conv_force_high <= 1'b0;
			diag_conv_req <= 1'b0;
			quarter_gain_path <= 1'b0;
			diag_cmp_req <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (state_r == ST_IDLE && seq_start)
				scan_r <= scan_config;
			conv_force_low <= (state_nxt == ST_ZS_REQ) || (state_nxt == ST_ZS_WAIT);
			conv_force_high <= (state_nxt == ST_FS_REQ) || (state_nxt == ST_FS_WAIT);
			diag_conv_req <= (state_nxt == ST_ZS_REQ) || (state_nxt == ST_FS_REQ);
			quarter_gain_path <= (state_nxt == ST_CA_REQ) || (state_nxt == ST_CA_WAIT);
			diag_cmp_req <= (state_nxt == ST_CA_REQ);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Result paths: calibration touches converter results only.
	// Diagnostic conversions never reach the result outputs.
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			result_valid <= 1'b0;
			result_data <= {RES_W{1'b0}};
			cmp_result_valid <= 1'b0;
			cmp_result_data <= {RES_W{1'b0}};
		end else begin
			result_valid <= conv_valid && (state_r == ST_ACQ);
			if (conv_valid && state_r == ST_ACQ) begin
				if (cal_en)
					result_data <= cal_correct(conv_data, cal_offset_r);
				else
					result_data <= conv_data;
			end
			cmp_result_valid <= cmp_valid && (state_r == ST_ACQ);
			if (cmp_valid && state_r == ST_ACQ)
				cmp_result_data <= cmp_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky alert status; a new event wins over a clear in the same cycle.
	// The clear register is write-one-to-clear and reads back as zero.
	always @* begin
		ev_set = 5'h00;
		ev_clr = 5'h00;
		ev_set[`ACQ_IRQ_ZS] = (state_r == ST_ZS_WAIT) && conv_valid &&
			(conv_data != `ACQ_ZS_EXPECT);
		ev_set[`ACQ_IRQ_FS] = (state_r == ST_FS_WAIT) && conv_valid &&
			(conv_data != `ACQ_FS_EXPECT);
		ev_set[`ACQ_IRQ_OVER] = (state_r == ST_CA_WAIT) && cmp_valid &&
			(cmp_data > acc_upper_r);
		ev_set[`ACQ_IRQ_UNDER] = (state_r == ST_CA_WAIT) && cmp_valid &&
			(cmp_data < acc_lower_r);
		ev_set[`ACQ_IRQ_DONE] = seq_busy && (state_nxt == ST_IDLE);
		if (wr_pend_r && addr_r == `ACQ_IRQ_CLR_ADDR)
			ev_clr = hwdata[4:0];
		irq_stat_nxt = (irq_stat_r & ~ev_clr) | ev_set;
	end

	always @(posedge sys_clk) begin
		if (!reset_n)
			irq_stat_r <= `ACQ_IRQ_RST;
		else
			irq_stat_r <= irq_stat_nxt;
	end

	assign alert_conv_zero_scale = irq_stat_r[`ACQ_IRQ_ZS];
	assign alert_conv_full_scale = irq_stat_r[`ACQ_IRQ_FS];
	assign alert_cmp_acc_over = irq_stat_r[`ACQ_IRQ_OVER];
	assign alert_cmp_acc_under = irq_stat_r[`ACQ_IRQ_UNDER];
	assign irq = |(irq_stat_r & irq_en_r);

	////////////////////////////////////////////////////////////////////////
	// Thermistor bias switch, registered so that the pin never glitches.
	always @(posedge sys_clk) begin
		if (!reset_n)
			therm_bias_r <= 1'b0;
		else if (therm_bias_pin_mode[1])
			therm_bias_r <= therm_bias_pin_mode[0];
		else
			therm_bias_r <= (state_nxt == ST_ACQ);
	end

	assign therm_bias_pin = therm_bias_r;

	////////////////////////////////////////////////////////////////////////
	// Oversampling sample enable, fixed only when oversampling is on.
	rate_tick_gen #(
		.CNT_W(17),
		.DIV_50(DIV_50),
		.DIV_60(DIV_60)
	) u_rate_tick (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.paced(oversample_ratio_sel != 3'h0),
		.freq_sel(freq_sel),
		.tick(sample_tick)
	);

endmodule

// *** dv/acq_cfg_asserts.sv ***
`timescale 1ns/100ps

module acq_cfg_asserts (
	// Clock and reset.
	input wire sys_clk,
	input wire reset_n,
	// Bus.
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	// Engine and paths.
	input wire [2:0] oversample_ratio_sel,
	input wire acq_active,
	input wire sample_tick,
	input wire conv_valid,
	input wire [11:0] conv_data,
	input wire conv_force_low,
	input wire conv_force_high,
	input wire diag_conv_req,
	input wire cmp_valid,
	input wire [11:0] cmp_data,
	input wire quarter_gain_path,
	input wire diag_cmp_req,
	input wire cmp_result_valid,
	input wire [11:0] cmp_result_data,
	input wire alert_conv_zero_scale,
	input wire alert_conv_full_scale
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_read_wait: assert property (
		hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read data phase length wrong");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_zs_then_fs: assert property (
		conv_force_low && !diag_conv_req && conv_valid |->
		##[1:2] conv_force_high && diag_conv_req)
		else $error("full scale step missing");
	a_force_idle: assert property (
		acq_active |-> !conv_force_low && !conv_force_high && !quarter_gain_path)
		else $error("diagnostic forcing during acquisition");
	a_zs_alert: assert property (
		conv_force_low && !diag_conv_req && conv_valid && conv_data != 12'h000 |->
		##[1:2] alert_conv_zero_scale)
		else $error("zero scale alert missing");
	a_fs_alert: assert property (
		conv_force_high && !diag_conv_req && conv_valid && conv_data != 12'hfff |->
		##[1:2] alert_conv_full_scale)
		else $error("full scale alert missing");
	a_quarter_req: assert property ($rose(quarter_gain_path) |-> diag_cmp_req)
		else $error("accuracy request missing");
	a_cmp_raw: assert property (
		acq_active && cmp_valid |=> cmp_result_valid && cmp_result_data == $past(cmp_data))
		else $error("comparator result altered");
	a_free_tick: assert property (oversample_ratio_sel == 3'h0 [*3] |-> sample_tick)
		else $error("sample tick not free running");
endmodule

bind acquisition_config_control acq_cfg_asserts chk (.*);

// *** dv/tb.sv ***
`timescale 1ns/100ps
`include "acq_defs.vh"

module tb;
	reg sys_clk, reset_n, hsel, hwrite, seq_start, seq_done, conv_valid, cmp_valid;
	reg [11:0] haddr, conv_data, cmp_data;
	reg [1:0] htrans;
	reg [2:0] hsize, scan_config, oversample_ratio_sel;
	reg [31:0] hwdata, r;
	wire hreadyout, hresp, acq_active, seq_busy, sample_tick, conv_force_low, conv_force_high;
	wire diag_conv_req, result_valid, quarter_gain_path, diag_cmp_req, cmp_result_valid, irq;
	wire therm_bias_pin, alert_conv_zero_scale, alert_conv_full_scale;
	wire alert_cmp_acc_over, alert_cmp_acc_under;
	wire [31:0] hrdata;
	wire [11:0] result_data, cmp_result_data;
	wire hready = hreadyout;
	int miscompares = 0;
	int n_compared = 0;
	int g;
	typedef struct {logic [15:0] cfg; logic [2:0] ratio; logic therm; int gap;} row_t;
	row_t rows [6];

	acquisition_config_control #(.DIV_50(10), .DIV_60(8)) uut (.*);

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////
	task test_done;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task chk(input string nm, input [31:0] e, input [31:0] v);
		n_compared++;
		if (v !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, v);
		end
	endtask

	function logic sig(input int k);
		case (k)
			0: sig = hreadyout;
			1: sig = conv_force_low;
			2: sig = conv_force_high;
			3: sig = quarter_gain_path;
			4: sig = !seq_busy;
			5: sig = result_valid;
			6: sig = cmp_result_valid;
			default: sig = sample_tick;
		endcase
	endfunction

	// Waits at falling edges until the chosen signal is high.
	task wt(input int k);
		int n;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (sig(k) !== 1'b1 && n < 200);
		if (n >= 200) begin
			miscompares++;
			test_done;
		end
	endtask

	task bus(input [11:0] a, input w, input [31:0] d);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wt(0);
		@(posedge sys_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wt(0);
		@(posedge sys_clk);
		r = hrdata;
		@(negedge sys_clk);
	endtask

	task rc(input [11:0] a, input [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk("read", e, r);
	endtask

	// Pulses start, done, converter or comparator strobe for one cycle; returns at its last edge.
	task drv(input int k, input [11:0] d);
		@(posedge sys_clk);
		case (k)
			0: seq_start <= 1'b1;
			1: seq_done <= 1'b1;
			2: conv_valid <= 1'b1;
			default: cmp_valid <= 1'b1;
		endcase
		conv_data <= d;
		cmp_data <= d;
		@(posedge sys_clk);
		{seq_start, seq_done, conv_valid, cmp_valid} <= 4'h0;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		{reset_n, hsel, hwrite, seq_start, seq_done, conv_valid, cmp_valid} = 7'h0;
		{haddr, conv_data, cmp_data, htrans, hwdata} = 70'h0;
		{scan_config, oversample_ratio_sel} = 6'h0;
		hsize = 3'h2;
		rows = '{'{16'h0000, 3'h1, 1'b0, 1}, '{16'h0a00, 3'h1, 1'b0, 10},
			'{16'h1400, 3'h5, 1'b0, 8}, '{16'h1e00, 3'h7, 1'b1, 8},
			'{16'h0800, 3'h0, 1'b0, 1}, '{16'he600, 3'h0, 1'b1, 1}};
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'b1;
		rc(`ACQ_CFG_ADDR, 32'h0);
		chk("bias", 1'b0, therm_bias_pin);
		foreach (rows[i]) begin
			@(posedge sys_clk);
			oversample_ratio_sel <= rows[i].ratio;
			bus(`ACQ_CFG_ADDR, 1'b1, {16'hffff, rows[i].cfg | 16'h01ff});
			rc(`ACQ_CFG_ADDR, {16'h0, rows[i].cfg});
			chk("bias", rows[i].therm, therm_bias_pin);
			repeat (3) @(posedge sys_clk);
			wt(7);
			g = 0;
			do begin
				@(negedge sys_clk);
				g++;
			end while (sample_tick !== 1'b1 && g < 100);
			chk("gap", rows[i].gap, g);
		end
		bus(`ACQ_ACC_UPPER_ADDR, 1'b1, 32'h500);
		bus(`ACQ_ACC_LOWER_ADDR, 1'b1, 32'h300);
		bus(`ACQ_CAL_OFFSET_ADDR, 1'b1, 32'h10);
		bus(`ACQ_IRQ_EN_ADDR, 1'b1, 32'h1f);
		bus(`ACQ_CFG_ADDR, 1'b1, 32'ha000);
		@(posedge sys_clk);
		scan_config <= 3'h0;
		drv(0, 12'h0);
		@(negedge sys_clk);
		chk("bias", 1'b1, therm_bias_pin);
		drv(2, 12'h100);
		wt(5);
		chk("raw", 12'h100, result_data);
		bus(`ACQ_CFG_ADDR, 1'b1, 32'he000);
		drv(2, 12'hff8);
		wt(5);
		chk("cal", 12'hfff, result_data);
		drv(3, 12'h123);
		wt(6);
		chk("cmp", 12'h123, cmp_result_data);
		drv(1, 12'h0);
		wt(1);
		chk("zsreq", 1'b1, diag_conv_req);
		drv(2, 12'h001);
		wt(2);
		drv(2, 12'hfff);
		wt(4);
		chk("zs", 1'b1, alert_conv_zero_scale);
		chk("fs", 1'b0, alert_conv_full_scale);
		chk("qgp", 1'b0, quarter_gain_path);
		chk("irq", 1'b1, irq);
		bus(`ACQ_IRQ_EN_ADDR, 1'b1, 32'h0);
		chk("mask", 1'b0, irq);
		bus(`ACQ_IRQ_EN_ADDR, 1'b1, 32'h1f);
		bus(`ACQ_IRQ_CLR_ADDR, 1'b1, 32'h1f);
		rc(`ACQ_IRQ_STAT_ADDR, 32'h0);
		chk("clr", 1'b0, irq);
		drv(0, 12'h0);
		drv(1, 12'h0);
		wt(1);
		drv(2, 12'h000);
		wt(2);
		drv(2, 12'h7ff);
		wt(4);
		chk("fs", 1'b1, alert_conv_full_scale);
		chk("zs", 1'b0, alert_conv_zero_scale);
		bus(`ACQ_IRQ_CLR_ADDR, 1'b1, 32'h1f);
		@(posedge sys_clk);
		scan_config <= 3'h2;
		drv(0, 12'h0);
		drv(1, 12'h0);
		wt(3);
		chk("cmpreq", 1'b1, diag_cmp_req);
		chk("nozs", 1'b0, conv_force_low);
		drv(3, 12'h600);
		wt(4);
		rc(`ACQ_IRQ_STAT_ADDR, 32'h14);
		chk("accov", 1'b1, alert_cmp_acc_over);
		chk("accuv", 1'b0, alert_cmp_acc_under);
		bus(`ACQ_CFG_ADDR, 1'b1, 32'h2000);
		@(posedge sys_clk);
		scan_config <= 3'h1;
		drv(0, 12'h0);
		drv(1, 12'h0);
		wt(3);
		chk("nozs", 1'b0, conv_force_low);
		drv(3, 12'h2ff);
		wt(4);
		bus(`ACQ_IRQ_STAT_ADDR, 1'b1, 32'hff);
		rc(`ACQ_IRQ_STAT_ADDR, 32'h1c);
		chk("accuv", 1'b1, alert_cmp_acc_under);
		rc(`ACQ_IRQ_CLR_ADDR, 32'h0);
		rc(12'h100, 32'h0);
		@(posedge sys_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		rc(`ACQ_CFG_ADDR, 32'h0);
		rc(`ACQ_IRQ_STAT_ADDR, 32'h0);
		test_done;
	end
endmodule
